// ### pfc_regs.svh
// constants for the period frequency counter
`ifndef PFC_REGS_SVH
`define PFC_REGS_SVH
`define PFC_TIMEBASE_MHZ    100
`define PFC_TICK_NS         10
`define PFC_NUM_INPUTS      6
`define PFC_NUM_CUTOFFS     13
`define PFC_TICK_W          32
`define PFC_SCALE_W         16
`define PFC_CUTOFF_W        4
`define PFC_SEL_W           3
`endif

// ### pfc_pkg.sv
// types for the period frequency counter
package pfc_pkg;
   typedef enum logic [2:0] {
      PFC_IDLE    = 3'b001,
      PFC_WAIT    = 3'b010,
      PFC_MEASURE = 3'b100
   } pfc_state_t;
endpackage : pfc_pkg

// ### pfc_smooth.sv
// second order low pass smoothing of tick results
`timescale 1ns/1ps
`default_nettype none
module pfc_smooth
   import pfc_pkg::*;
#(
   parameter int TW = 32,
   parameter int CW = 4
)(
   input  wire logic          mclk_in,    // timebase clock
   input  wire logic          rst_in,     // sync reset
   input  wire logic          clear_in,   // restart filter
   input  wire logic          valid_in,   // new sample
   input  wire logic [TW-1:0] sample_in,  // raw ticks of one period
   input  wire logic [CW-1:0] cutoff_in,  // cutoff index 0..12
   output logic               valid_out,  // filtered sample valid
   output logic [TW-1:0]      result_out  // filtered ticks
);
   localparam int FW = TW + 16;
   initial if (TW < 8 || CW < 4) $error("pfc_smooth: width too small");
   logic [FW-1:0] s1_q;
   logic [FW-1:0] s2_q;
   logic          primed_q;
   logic [4:0]    k;
   // shift 15 is the lowest cutoff, 3 the highest
   function automatic logic [4:0] shift_of(input logic [CW-1:0] c);
      shift_of = (c > CW'(12)) ? 5'h0F : 5'(5'h0F - 5'(c));
   endfunction : shift_of
   assign k = shift_of(cutoff_in);
   // two cascaded first order sections give a second order response
   always_ff @(posedge mclk_in)
   begin
      if (rst_in || clear_in)
      begin
         s1_q       <= '0;
         s2_q       <= '0;
         primed_q   <= 1'b0;
         valid_out  <= 1'b0;
         result_out <= '0;
      end
      else
      begin
         valid_out <= valid_in;
         if (valid_in)
         begin
            if (!primed_q)
            begin
               s1_q       <= {sample_in, 16'h0000};
               s2_q       <= {sample_in, 16'h0000};
               primed_q   <= 1'b1;
               result_out <= sample_in;
            end
            else
            begin
               s1_q       <= s1_q + ({sample_in, 16'h0000} >> k) - (s1_q >> k);
               s2_q       <= s2_q + (s1_q >> k) - (s2_q >> k);
               result_out <= s2_q[FW-1:16];
            end
         end
      end
   end
endmodule : pfc_smooth
`default_nettype wire

// ### pfc_counter.sv
// period frequency counter channel with edge counting mode
`timescale 1ns/1ps
`default_nettype none
`include "pfc_regs.svh"
// Behaviour
// [R1] each tick counts one 10 ns period of the 100 MHz clock
// [R2] result is a tick count and a scaling factor
// [R3] outputs always hold the latest completed result
// [R4] input terminal and active edge are selectable
// [R5] with smoothing on every period passes a second order filter
// [R6] thirteen cutoff settings per channel, lowest is 1 Hz
// [R7] smoothing on ignores divisor, measurement time and max period
// [R8] nonzero divisor N averages N consecutive periods
// [R9] nonzero measurement time averages whole periods inside the window; code ends at the first active edge once the window has elapsed
// [R10] both set: whichever criterion completes first is reported
// [R11] zero disables a criterion; divisor 1 measures one period
// [R12] period above maximum gives a zero result
// [R13] maximum period zero disables the timeout
// [R14] once armed, measurement starts at the first active edge
// [R15] results read zero until first measurement after arming
// [R16] edge mode counts active edges, running count readable
// [R17] scaling factor equals number of periods accumulated
module pfc_counter
   import pfc_pkg::*;
#(
   parameter int NIN = `PFC_NUM_INPUTS,
   parameter int TW  = `PFC_TICK_W,
   parameter int SW  = `PFC_SCALE_W
)(
   input  wire logic                     mclk_in,      // 100 MHz timebase
   input  wire logic                     rst_in,       // sync reset, high
   input  wire logic [NIN-1:0]           sig_in,       // conditioned inputs
   input  wire logic [`PFC_SEL_W-1:0]    src_sel_in,   // input terminal select
   input  wire logic                     edge_fall_in, // 1 falling, 0 rising
   input  wire logic                     arm_in,       // level: counter armed
   input  wire logic                     edge_mode_in, // 1 edge counting
   input  wire logic                     smooth_en_in, // smoothing filter on
   input  wire logic [`PFC_CUTOFF_W-1:0] cutoff_in,    // cutoff index 0..12
   input  wire logic [SW-1:0]            divisor_in,   // periods to average
   input  wire logic [TW-1:0]            meas_time_in, // window in ticks
   input  wire logic [TW-1:0]            max_per_in,   // timeout in ticks
   output logic [TW-1:0]                 ticks_out,    // tick count or edges
   output logic [SW-1:0]                 scale_out,    // scaling factor
   output logic                          ready_out,    // first result done
   output logic                          update_out,   // new result pulse
   output logic                          overflow_out  // tick or period counter overflow
);
   localparam int TICK_NS = 1000 / `PFC_TIMEBASE_MHZ;
   initial if (NIN < 1 || NIN > (1 << `PFC_SEL_W) || TW < 8 || SW < 2
               || TICK_NS != `PFC_TICK_NS)
      $error("pfc_counter: unsupported parameters");

   logic [NIN-1:0] sync1_q;
   logic [NIN-1:0] sync2_q;
   logic           sel_q;
   logic           prev_q;
   logic           armed_q;
   logic           act_edge;
   pfc_state_t     state_q;
   logic [TW-1:0]  acc_q;      // ticks since first edge of this result
   logic [TW-1:0]  per_q;      // ticks since last edge
   logic [TW-1:0]  win_q;      // ticks since measurement window opened
   logic [SW-1:0]  nper_q;     // periods accumulated
   logic [TW-1:0]  edges_q;
   logic           sm_valid;
   logic [TW-1:0]  sm_result;
   logic           div_done;
   logic           time_done;
   logic           timeout;
   logic           acc_full;
   logic           raw_done;
   logic           start;

   function automatic logic sel_bit(input logic [NIN-1:0] v,
                                    input logic [`PFC_SEL_W-1:0] s);
      sel_bit = (int'(s) < NIN) ? v[s] : 1'b0;
   endfunction : sel_bit

   // two flop synchroniser per input
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= sig_in;
         sync2_q <= sync1_q;
      end
   end

   // source selection and edge detection
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         sel_q  <= 1'b0;
         prev_q <= 1'b0;
      end
      else
      begin
         sel_q  <= sel_bit(sync2_q, src_sel_in); // R4
         prev_q <= sel_q;
      end
   end
   // polarity applied after the flops: an idle low line gives no false edge
   assign act_edge = edge_fall_in ? (prev_q && !sel_q) : (sel_q && !prev_q); // R4

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         armed_q <= 1'b0;
      else
         armed_q <= arm_in;
   end
   assign start = arm_in && !armed_q;

   // completion criteria
   assign div_done  = (divisor_in != '0) && (nper_q + SW'(1) >= divisor_in); // R8 R11
   assign time_done = (meas_time_in != '0) && (win_q + TW'(1) >= meas_time_in); // R9
   assign timeout   = (max_per_in != '0) && (per_q >= max_per_in); // R12 R13
   assign acc_full  = (acc_q == '1) || (nper_q == '1);
   // default criterion when both disabled: one period
   assign raw_done  = act_edge && (div_done || time_done || // R10
                      ((divisor_in == '0) && (meas_time_in == '0)));

   // measurement sequencer
   always_ff @(posedge mclk_in)
   begin
      if (rst_in || !arm_in || edge_mode_in)
      begin
         state_q <= PFC_IDLE;
         acc_q   <= '0;
         per_q   <= '0;
         win_q   <= '0;
         nper_q  <= '0;
      end
      else
      begin
         case (state_q)
            PFC_IDLE:
               state_q <= PFC_WAIT;
            PFC_WAIT:
               if (act_edge) // R14
               begin
                  state_q <= PFC_MEASURE;
                  acc_q   <= TW'(1);
                  per_q   <= TW'(1);
                  win_q   <= TW'(1);
                  nper_q  <= '0;
               end
            PFC_MEASURE:
               if (smooth_en_in) // R7
               begin
                  acc_q  <= act_edge ? TW'(1) : acc_q + TW'(1); // R1
                  per_q  <= act_edge ? TW'(1) : per_q + TW'(1);
                  nper_q <= '0;
               end
               else if (raw_done || (!smooth_en_in && act_edge && acc_full))
               begin
                  acc_q  <= TW'(1);
                  per_q  <= TW'(1);
                  win_q  <= TW'(1);
                  nper_q <= '0;
               end
               else if (timeout)
               begin
                  state_q <= PFC_WAIT;
               end
               else
               begin
                  acc_q  <= acc_full ? acc_q : acc_q + TW'(1); // R1
                  per_q  <= act_edge ? TW'(1) : per_q + TW'(1);
                  win_q  <= win_q + TW'(1);
                  nper_q <= act_edge ? nper_q + SW'(1) : nper_q;
               end
            default:
               state_q <= PFC_IDLE;
         endcase
      end
   end

   pfc_smooth #(
      .TW (TW),
      .CW (`PFC_CUTOFF_W)
   ) u_smooth (
      .mclk_in    (mclk_in),
      .rst_in     (rst_in),
      .clear_in   (!arm_in || !smooth_en_in),
      .valid_in   (smooth_en_in && state_q == PFC_MEASURE && act_edge), // R5
      .sample_in  (acc_q),
      .cutoff_in  (cutoff_in), // R6
      .valid_out  (sm_valid),
      .result_out (sm_result)
   );

   // edge counting
   always_ff @(posedge mclk_in)
   begin
      if (rst_in || !arm_in || !edge_mode_in)
         edges_q <= '0;
      else if (act_edge)
         edges_q <= edges_q + TW'(1); // R16
   end

   // result registers
   always_ff @(posedge mclk_in)
   begin
      update_out <= 1'b0;
      if (rst_in || start)
      begin
         ticks_out    <= '0; // R15
         scale_out    <= '0; // R15
         ready_out    <= 1'b0;
         overflow_out <= 1'b0;
      end
      else if (edge_mode_in)
      begin
         ticks_out <= edges_q; // R16
         scale_out <= '0;
      end
      else if (smooth_en_in)
      begin
         if (sm_valid)
         begin
            ticks_out  <= sm_result; // R5 R3
            scale_out  <= SW'(1);
            ready_out  <= 1'b1;
            update_out <= 1'b1;
         end
      end
      else if (state_q == PFC_MEASURE && act_edge
               && (raw_done || acc_full))
      begin
         ticks_out    <= acc_q; // R2 R3
         scale_out    <= nper_q + SW'(1); // R17
         ready_out    <= 1'b1;
         update_out   <= 1'b1;
         overflow_out <= acc_full && !raw_done;
      end
      else if (state_q == PFC_MEASURE && timeout)
      begin
         ticks_out  <= '0; // R12
         scale_out  <= '0;
         ready_out  <= 1'b1;
         update_out <= 1'b1;
      end
   end

   // outside edge mode and arming, result changes only with an update pulse
   stable_result_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R3
      !update_out && !edge_mode_in && !$past(start) && !$past(edge_mode_in)
      |-> $stable(ticks_out))
      else $error("result changed without update");
   zero_before_ready_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R15
      !ready_out && !edge_mode_in |-> ticks_out == '0 && scale_out == '0)
      else $error("nonzero result before first measurement");
   arm_clears_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R15
      start |=> !ready_out && ticks_out == '0)
      else $error("arming did not clear result");
   wait_edge_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R14
      state_q == PFC_WAIT && arm_in && !edge_mode_in && !act_edge |=> state_q != PFC_MEASURE)
      else $error("measurement started without edge");
   scale_match_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R17
      update_out && !smooth_en_in && !$past(smooth_en_in) && ticks_out != '0
      |-> scale_out != '0)
      else $error("scale zero with nonzero ticks");
   divisor_cap_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R8
      update_out && !$past(smooth_en_in) && $past(divisor_in) != '0
      && $past(meas_time_in) == '0 && !$past(acc_full) && ticks_out != '0
      |-> scale_out == $past(divisor_in))
      else $error("period count differs from divisor");
   timeout_zero_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R12
      state_q == PFC_MEASURE && timeout && !act_edge && !smooth_en_in && arm_in
      && !edge_mode_in && !start |=> ticks_out == '0 && update_out)
      else $error("timeout did not zero result");
   no_timeout_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R13
      max_per_in == '0 && state_q == PFC_MEASURE && arm_in && !edge_mode_in
      |=> state_q == PFC_MEASURE)
      else $error("timeout fired while disabled");
   edge_count_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R16
      edge_mode_in && arm_in && $past(edge_mode_in) && $past(arm_in) && act_edge
      |=> edges_q == $past(edges_q) + TW'(1))
      else $error("edge not counted");

   // sequencer and result checks
   first_edge_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R14
      state_q == PFC_WAIT && act_edge && arm_in && !edge_mode_in
      |=> state_q == PFC_MEASURE && acc_q == TW'(1))
      else $error("first active edge did not start measurement");
   disarm_idle_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R14
      !arm_in
      |=> state_q == PFC_IDLE && nper_q == '0)
      else $error("disarmed counter kept measuring");
   tick_step_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R1
      state_q == PFC_MEASURE && arm_in && !edge_mode_in && !act_edge && !acc_full
      && !(timeout && !smooth_en_in)
      |=> acc_q == $past(acc_q) + TW'(1))
      else $error("tick count did not advance by one");
   smooth_scale_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R5
      update_out && $past(smooth_en_in) && !$past(edge_mode_in)
      |-> scale_out == SW'(1) && ticks_out == $past(sm_result))
      else $error("smoothed result not taken from filter");
   smooth_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R7
      state_q == PFC_MEASURE && smooth_en_in && arm_in && !edge_mode_in
      |=> state_q == PFC_MEASURE && nper_q == '0)
      else $error("smoothing obeyed averaging or timeout settings");
   single_period_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R11
      update_out && $past(divisor_in) == '0 && $past(meas_time_in) == '0
      && !$past(smooth_en_in) && !$past(edge_mode_in) && ticks_out != '0
      |-> scale_out == SW'(1) && !overflow_out)
      else $error("disabled criteria did not give one period");
   window_end_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R9
      update_out && $past(divisor_in) == '0 && $past(meas_time_in) != '0
      && !$past(smooth_en_in) && !$past(edge_mode_in) && !overflow_out && ticks_out != '0
      |-> $past(win_q) + TW'(1) >= $past(meas_time_in))
      else $error("window result before window elapsed");
   first_wins_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R10
      update_out && $past(divisor_in) != '0 && $past(meas_time_in) != '0
      && !$past(smooth_en_in) && !$past(edge_mode_in) && !overflow_out && ticks_out != '0
      |-> scale_out <= $past(divisor_in))
      else $error("dynamic averaging ran past the divisor");
   timeout_wait_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R12
      state_q == PFC_MEASURE && timeout && !act_edge && !smooth_en_in && arm_in
      && !edge_mode_in
      |=> state_q == PFC_WAIT && scale_out == '0)
      else $error("timeout did not restart at a new edge");
   edge_scale_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R16
      edge_mode_in && !start
      |=> scale_out == '0 && ticks_out == $past(edges_q) && !update_out)
      else $error("edge mode result not the running count");
   ready_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R3
      ready_out && !start
      |=> ready_out)
      else $error("ready dropped without rearming");
   update_ready_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R15
      update_out
      |-> ready_out)
      else $error("result without ready");
endmodule : pfc_counter
`default_nettype wire

// ### pfc_sig_src.sv
// conditioned comparator output model: square wave while enabled
`timescale 1ns/1ps
`default_nettype none
module pfc_sig_src
(
   input  wire logic       mclk_in,  // timebase clock
   input  wire logic       en_in,    // run the wave, low holds the line low
   input  wire logic [7:0] high_in,  // high time in cycles
   input  wire logic [7:0] low_in,   // low time in cycles
   output logic            line_out  // conditioned input level
);
   logic [7:0] cnt_q;

   // wave starts in its low phase, so the first rising edge comes low_in cycles in
   always_ff @(posedge mclk_in)
   begin
      if (!en_in)
      begin
         line_out <= 1'b0;
         cnt_q    <= 8'h00;
      end
      else if (cnt_q >= (line_out ? high_in : low_in) - 8'h01)
      begin
         line_out <= ~line_out;
         cnt_q    <= 8'h00;
      end
      else
      begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
endmodule : pfc_sig_src
`default_nettype wire

// ### tb.sv
// self-checking testbench for the period frequency counter
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        mclk_in, rst_in, edge_fall_in, arm_in, edge_mode_in, smooth_en_in;
   logic [5:0]  sig_in;
   logic [2:0]  src_sel_in;
   logic [3:0]  cutoff_in;
   logic [15:0] divisor_in, scale_out;
   logic [31:0] meas_time_in, max_per_in, ticks_out;
   logic        ready_out, update_out, overflow_out, en, line;
   logic [7:0]  hi, lo;
   logic [31:0] rnd_q = 32'h00000032;
   logic [47:0] exp_q[$];
   int          n_errors, cmp_count;

   pfc_counter i_dut (.mclk_in, .rst_in, .sig_in, .src_sel_in, .edge_fall_in, .arm_in,
      .edge_mode_in, .smooth_en_in, .cutoff_in, .divisor_in, .meas_time_in, .max_per_in,
      .ticks_out, .scale_out, .ready_out, .update_out, .overflow_out);
   pfc_sig_src i_src (.mclk_in, .en_in(en), .high_in(hi), .low_in(lo), .line_out(line));

   // unselected lines toggle randomly every cycle
   assign sig_in = (rnd_q[13:8] & ~(6'h01 << src_sel_in)) | ({6{line}} & (6'h01 << src_sel_in));

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs

   initial
   begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end

   always @(posedge mclk_in) rnd_q <= #1 xs(rnd_q);

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask : cyc

   task automatic check(input logic [48:0] got, input logic [48:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   always @(negedge mclk_in)
      if (update_out === 1'b1 && edge_mode_in === 1'b0)
      begin
         if (exp_q.size() == 0)
         begin
            n_errors++;
            $display("wrong value at %0t: unexpected result", $time);
         end
         else
         begin
            check({overflow_out, ticks_out, scale_out}, {1'b0, exp_q.pop_front()});
            check({48'h000000000000, ready_out}, 49'h0000000000001);
         end
      end

   task automatic wait_empty();
      int i;
      for (i = 0; i < 5000 && exp_q.size() != 0; i++) cyc(1);
      if (exp_q.size() != 0)
      begin
         n_errors++;
         $display("wrong value at %0t: result missing", $time);
         exp_q.delete();
      end
   endtask : wait_empty

   task automatic meas(input int sel, fall, div, m, maxp, sm, cut, nres, stop);
      int per;
      int k;
      hi = 8'h05 + {4'h0, rnd_q[3:0]};
      lo = 8'h05 + {4'h0, rnd_q[7:4]};
      per = int'(hi) + int'(lo);
      k = (div != 0) ? div : 1000;
      if (m >= 0 && m + 1 < k) k = m + 1;
      if (k == 1000 || sm != 0) k = 1;
      src_sel_in = sel[2:0];
      edge_fall_in = fall[0];
      divisor_in = div[15:0];
      meas_time_in = (m < 0) ? 32'h00000000 : 32'(m * per + per / 2);
      max_per_in = maxp[31:0];
      smooth_en_in = sm[0];
      cutoff_in = cut[3:0];
      cyc(4);
      arm_in = 1'b1;
      cyc(2);
      check({ready_out, ticks_out, scale_out}, 49'h0);
      en = 1'b1;
      repeat (nres) exp_q.push_back({32'(k * per), 16'(k)});
      wait_empty();
      if (stop != 0)
      begin
         en = 1'b0;
         if (maxp != 0) exp_q.push_back(48'h0);
         wait_empty();
         cyc(300);
      end
      en = 1'b0;
      arm_in = 1'b0;
      cyc(60);
   endtask : meas

   task automatic complete_run();
      if (n_errors == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run

   initial
   begin
      #400000;
      n_errors++;
      complete_run();
   end

   initial
   begin
      rst_in = 1'b1;
      {edge_fall_in, arm_in, edge_mode_in, smooth_en_in, en} = 5'h00;
      src_sel_in = 3'h0;
      cutoff_in = 4'h0;
      divisor_in = 16'h0001;
      meas_time_in = 32'h00000000;
      max_per_in = 32'h00000000;
      hi = 8'h05;
      lo = 8'h05;
      cyc(5);
      rst_in = 1'b0;
      meas(0, 0, 1, -1, 0, 0, 0, 3, 0);
      meas(3, 1, 4, -1, 0, 0, 0, 2, 0);
      meas(5, 0, 0, 2, 0, 0, 0, 2, 0);
      meas(2, 1, 3, 9, 0, 0, 0, 2, 0);
      meas(1, 0, 6, 1, 0, 0, 0, 2, 0);
      meas(4, 0, 0, -1, 0, 0, 0, 2, 0);
      for (int c = 0; c < 13; c++) meas(c % 6, c % 2, 5, 0, 5, 1, c, 3, 0);
      meas(0, 0, 1, -1, 60, 0, 0, 1, 1);
      meas(0, 0, 1, -1, 0, 0, 0, 1, 1);
      // edge counting: ten rising edges in 100 cycles of a 10 cycle wave
      hi = 8'h05;
      lo = 8'h05;
      src_sel_in = 3'h2;
      edge_fall_in = 1'b0;
      edge_mode_in = 1'b1;
      cyc(4);
      arm_in = 1'b1;
      cyc(2);
      en = 1'b1;
      cyc(100);
      en = 1'b0;
      cyc(10);
      check({17'h0, ticks_out}, 49'h0000_0000_000A);
      arm_in = 1'b0;
      cyc(5);
      edge_mode_in = 1'b0;
      cyc(5);
      complete_run();
   end
endmodule : tb
`default_nettype wire
